// [sdbsc_pkg.sv]
// sdbsc_pkg.sv: shared constants and types of the sdram bank state checker
// assumes a 10 MHz memory clock; all durations become whole clock cycles here
package sdbsc_pkg;

    localparam int CNT_W = 8;
    localparam int BA_W  = 3;

    // clock period and device times, in picoseconds
    localparam int CK_PS     = 100000;
    localparam int T_RP_PS   = 15000;
    localparam int T_RCD_PS  = 15000;
    localparam int T_RFC_PS  = 127500;
    localparam int T_WR_PS   = 15000;
    localparam int T_WTR_PS  = 7500;
    localparam int T_XSNR_PS = 137500;

    // least times round up, never below the given floor
    function automatic int cyc_up(input int t_ps, input int floor_cyc);
        int c;
        c = (t_ps + CK_PS - 1) / CK_PS;
        return (c > floor_cyc) ? c : floor_cyc;
    endfunction

    localparam int WTR_MIN_CYC    = 2;
    localparam int RP_CYC         = cyc_up(T_RP_PS, 1);
    localparam int RCD_CYC        = cyc_up(T_RCD_PS, 1);
    localparam int RFC_CYC        = cyc_up(T_RFC_PS, 1);
    localparam int WR_CYC         = cyc_up(T_WR_PS, 1);
    localparam int WTR_CYC        = cyc_up(T_WTR_PS, WTR_MIN_CYC);
    localparam int XSNR_CYC       = cyc_up(T_XSNR_PS, 1);
    localparam int MRD_CYC        = 2;
    localparam int RD_TO_WR_EXTRA = 2;

    // {ras_n, cas_n, we_n} with cs_n low
    localparam logic [2:0] ENC_NOP = 3'h7;
    localparam logic [2:0] ENC_ACT = 3'h3;
    localparam logic [2:0] ENC_RD  = 3'h5;
    localparam logic [2:0] ENC_WR  = 3'h4;
    localparam logic [2:0] ENC_PRE = 3'h2;
    localparam logic [2:0] ENC_REF = 3'h1;
    localparam logic [2:0] ENC_LM  = 3'h0;

    typedef enum logic [3:0] {
        CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_RDA, CMD_WR,
        CMD_WRA, CMD_PRE, CMD_PREA, CMD_REF, CMD_LM, CMD_SRE
    } sdbsc_cmd_t;

    typedef enum logic [7:0] {
        BK_IDLE = 8'h01, BK_ACTV = 8'h02, BK_ROW  = 8'h04, BK_RD  = 8'h08,
        BK_WR   = 8'h10, BK_RDAP = 8'h20, BK_WRAP = 8'h40, BK_PRE = 8'h80
    } sdbsc_bank_t;

    typedef enum logic [5:0] {
        DV_RUN  = 6'h01, DV_REF  = 6'h02, DV_MODE = 6'h04,
        DV_PREA = 6'h08, DV_SELF = 6'h10, DV_XIT  = 6'h20
    } sdbsc_dev_t;

endpackage

// [sdbsc_cmd_if.sv]
// sdbsc_cmd_if.sv: decoded command shared by decoder, checker and bank trackers
// assumes a single clock; all fields are combinational within one cycle
`timescale 1ns/10ps
interface sdbsc_cmd_if;
    import sdbsc_pkg::*;
    sdbsc_cmd_t      cmd;
    logic [BA_W-1:0] bank;
    logic            live;
    logic            take;
    modport dec (output cmd, bank, live);
    modport trk (input cmd, bank, take);
endinterface

// [sdbsc_decode.sv]
// sdbsc_decode.sv: turns the command pins into one decoded command per edge
// assumes the pins are sampled on ref_clk, the memory clock itself
`timescale 1ns/10ps
module sdbsc_decode
    import sdbsc_pkg::*;
(
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst,
    // command pins
    input  wire logic            cke,
    input  wire logic            cs_n,
    input  wire logic            ras_n,
    input  wire logic            cas_n,
    input  wire logic            we_n,
    input  wire logic            a10,
    input  wire logic [BA_W-1:0] ba,
    // decoded command
    sdbsc_cmd_if.dec             c
);
    logic       cke_prev;
    logic       next_cke_prev;
    logic [2:0] enc;

    always_comb begin
        enc           = {ras_n, cas_n, we_n};
        next_cke_prev = cke;
        c.bank        = ba;
        c.live        = cke_prev && cke;
        c.cmd         = CMD_DESEL;
        if (!cs_n && cke_prev && !cke) begin
            // falling clock enable with a refresh pattern enters self refresh
            c.cmd = (enc == ENC_REF) ? CMD_SRE : CMD_DESEL;
        end else if (!cs_n) begin
            case (enc)
                ENC_NOP: c.cmd = CMD_NOP;
                ENC_ACT: c.cmd = CMD_ACT;
                ENC_RD:  c.cmd = a10 ? CMD_RDA : CMD_RD;
                ENC_WR:  c.cmd = a10 ? CMD_WRA : CMD_WR;
                ENC_PRE: c.cmd = a10 ? CMD_PREA : CMD_PRE;
                ENC_REF: c.cmd = CMD_REF;
                ENC_LM:  c.cmd = CMD_LM;
                default: c.cmd = CMD_DESEL;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cke_prev <= 1'b0;
        end else begin
            cke_prev <= next_cke_prev;
        end
    end
endmodule

// [sdbsc_bank.sv]
// sdbsc_bank.sv: state and cycle counters of one bank
// assumes only commands the checker accepted are marked take
`timescale 1ns/10ps
module sdbsc_bank
    import sdbsc_pkg::*;
#(
    parameter int BANK_ID = 0,
    parameter int RP      = RP_CYC,
    parameter int RCD     = RCD_CYC,
    parameter int WR      = WR_CYC,
    parameter int HALF_BL = 4,
    parameter int RL      = 5
) (
    // clock and reset
    input  wire logic   ref_clk,
    input  wire logic   rst,
    // accepted command stream
    sdbsc_cmd_if.trk    c,
    // bank status
    output sdbsc_bank_t state,
    output logic        rec_busy
);
    localparam int WL = RL - 1;
    localparam logic [CNT_W-1:0] RP_L  = CNT_W'(RP - 1);
    localparam logic [CNT_W-1:0] RCD_L = CNT_W'(RCD - 1);
    localparam logic [CNT_W-1:0] BST_L = CNT_W'(HALF_BL - 1);
    localparam logic [CNT_W-1:0] REC_L = CNT_W'(WL + HALF_BL + WR - 1);
    localparam logic [CNT_W-1:0] RDA_L = CNT_W'(HALF_BL + RP - 1);
    localparam logic [CNT_W-1:0] WRA_L = CNT_W'(WL + HALF_BL + WR + RP - 1);

    sdbsc_bank_t      next_state;
    logic [CNT_W-1:0] cnt, next_cnt, rec, next_rec, age, next_age;
    logic             hit, pre_hit;

    always_comb begin
        hit        = c.take && (c.bank == BA_W'(BANK_ID));
        pre_hit    = c.take && (c.cmd == CMD_PREA || (hit && c.cmd == CMD_PRE));
        next_state = state;
        next_cnt   = (cnt != '0) ? cnt - 1'b1 : cnt;
        next_rec   = (rec != '0) ? rec - 1'b1 : rec;
        if (pre_hit) begin
            // a later precharge restarts the period
            next_state = BK_PRE;
            next_cnt   = RP_L;
        end else if (hit) begin
            case (c.cmd)
                CMD_ACT: begin
                    next_state = BK_ACTV;
                    next_cnt   = RCD_L;
                end
                CMD_RD: begin
                    next_state = BK_RD;
                    next_cnt   = BST_L;
                end
                CMD_RDA: begin
                    // access runs to the earliest precharge point, then the precharge
                    next_state = BK_RDAP;
                    next_cnt   = RDA_L;
                end
                CMD_WR: begin
                    next_state = BK_WR;
                    next_cnt   = BST_L;
                    next_rec   = REC_L;
                end
                CMD_WRA: begin
                    next_state = BK_WRAP;
                    next_cnt   = WRA_L;
                    next_rec   = REC_L;
                end
                default: next_state = state;
            endcase
        end else if (cnt == '0) begin
            case (state)
                BK_ACTV, BK_RD, BK_WR:    next_state = BK_ROW;
                BK_RDAP, BK_WRAP, BK_PRE: next_state = BK_IDLE;
                default:                  next_state = state;
            endcase
        end
        next_age = (next_state != state || hit || pre_hit) ? '0 :
                   (&age ? age : age + 1'b1);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= BK_IDLE;
            cnt   <= '0;
            rec   <= '0;
            age   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            rec   <= next_rec;
            age   <= next_age;
        end
    end

    assign rec_busy = (rec != '0);

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_ACT_ENTRY:
    assert property (hit && c.cmd == CMD_ACT |=> state == BK_ACTV && cnt == RCD_L)
        else $error("activate did not start the activating period");
    AST_RCD_EXIT:
    assert property (state == BK_ACTV && !c.take |=>
        state == ((int'($past(age)) == RCD - 1) ? BK_ROW : BK_ACTV))
        else $error("activating period length wrong");
    AST_RP_EXIT:
    assert property (state == BK_PRE && !c.take |=>
        state == ((int'($past(age)) == RP - 1) ? BK_IDLE : BK_PRE))
        else $error("precharge period length wrong");
    AST_RDAP_LEN:
    assert property (state == BK_RDAP && !c.take |=>
        state == ((int'($past(age)) == HALF_BL + RP - 1) ? BK_IDLE : BK_RDAP))
        else $error("read auto precharge length wrong");
    AST_WRAP_LEN:
    assert property (state == BK_WRAP && !c.take |=>
        state == ((int'($past(age)) == WL + HALF_BL + WR + RP - 1) ? BK_IDLE : BK_WRAP))
        else $error("write auto precharge length wrong");
endmodule

// [sdbsc_checker.sv]
// sdbsc_checker.sv: bank and device command state tracking with legality check
// assumes command pins are synchronous to ref_clk (the memory clock)
`timescale 1ns/10ps
module sdbsc_checker
    import sdbsc_pkg::*;
#(
    parameter int NUM_BANKS    = 8,
    parameter int READ_LATENCY = 5,
    parameter int BURST_LENGTH = 8,
    parameter int RP_CYCLES    = RP_CYC,
    parameter int RCD_CYCLES   = RCD_CYC,
    parameter int WR_CYCLES    = WR_CYC,
    parameter int WTR_CYCLES   = WTR_CYC,
    parameter int RFC_CYCLES   = RFC_CYC,
    parameter int XSNR_CYCLES  = XSNR_CYC,
    parameter int MRD_CYCLES   = MRD_CYC
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // memory command pins
    input  wire logic                 cke,
    input  wire logic                 cs_n,
    input  wire logic                 ras_n,
    input  wire logic                 cas_n,
    input  wire logic                 we_n,
    input  wire logic                 a10,
    input  wire logic [BA_W-1:0]      ba,
    // violation report
    output logic                      viol,
    output logic [BA_W-1:0]           viol_bank,
    output sdbsc_cmd_t                viol_cmd,
    // state view
    output logic [NUM_BANKS-1:0]      bank_idle,
    output sdbsc_dev_t                dev_state
);
    localparam int HALF_BL = BURST_LENGTH / 2;
    // gaps are minimum edges between commands, stored as gap minus one
    localparam logic [CNT_W-1:0] WR2RD_L =
        CNT_W'(READ_LATENCY - 1 + HALF_BL + WTR_CYCLES - 1);
    localparam logic [CNT_W-1:0] RD2WR_L  = CNT_W'(HALF_BL + RD_TO_WR_EXTRA - 1);
    localparam logic [CNT_W-1:0] SAME_L   = CNT_W'(HALF_BL - 1);
    localparam logic [CNT_W-1:0] RDDONE_L = CNT_W'(READ_LATENCY + HALF_BL - 1);
    localparam logic [CNT_W-1:0] RFC_L    = CNT_W'(RFC_CYCLES - 1);
    localparam logic [CNT_W-1:0] RP_L     = CNT_W'(RP_CYCLES - 1);
    localparam logic [CNT_W-1:0] MRD_L    = CNT_W'(MRD_CYCLES - 1);
    localparam logic [CNT_W-1:0] XSNR_L   = CNT_W'(XSNR_CYCLES - 1);

    sdbsc_cmd_if c ();

    sdbsc_bank_t            st [NUM_BANKS];
    logic [NUM_BANKS-1:0]   rec_busy;
    logic [NUM_BANKS-1:0]   pre_ok;

    sdbsc_decode u_dec (
        .ref_clk (ref_clk),
        .rst     (rst),
        .cke     (cke),
        .cs_n    (cs_n),
        .ras_n   (ras_n),
        .cas_n   (cas_n),
        .we_n    (we_n),
        .a10     (a10),
        .ba      (ba),
        .c       (c)
    );

    for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
        sdbsc_bank #(
            .BANK_ID (i),
            .RP      (RP_CYCLES),
            .RCD     (RCD_CYCLES),
            .WR      (WR_CYCLES),
            .HALF_BL (HALF_BL),
            .RL      (READ_LATENCY)
        ) u_bank (
            .ref_clk  (ref_clk),
            .rst      (rst),
            .c        (c),
            .state    (st[i]),
            .rec_busy (rec_busy[i])
        );
        assign bank_idle[i] = (st[i] == BK_IDLE);
        // a bank may be precharged when idle, open, reading, writing or already precharging, and only once write recovery has run out
        assign pre_ok[i] = (st[i] inside {BK_IDLE, BK_ROW, BK_RD, BK_WR, BK_PRE})
                           && !rec_busy[i];
    end

    // legality and command acceptance
    sdbsc_bank_t      tgt;
    logic             bank_ok, exec, chk, ok, sre_now, quiet, bad;
    logic [CNT_W-1:0] since_rd, since_wr, next_since_rd, next_since_wr;

    always_comb begin
        bank_ok = (int'(c.bank) < NUM_BANKS);
        tgt     = bank_ok ? st[c.bank] : BK_IDLE;
        exec    = !(c.cmd inside {CMD_DESEL, CMD_NOP});
        sre_now = (c.cmd == CMD_SRE);
        // no checking in self refresh or before the exit time is met
        chk     = c.live && (dev_state inside {DV_RUN, DV_REF, DV_MODE, DV_PREA});
        quiet   = (&bank_idle) && (since_rd >= RDDONE_L) && (since_wr >= WR2RD_L);
        case (c.cmd)
            CMD_ACT: ok = bank_ok && (tgt == BK_IDLE);
            CMD_RD, CMD_RDA: begin
                // other banks in any state allow this; only timing gaps apply
                ok = bank_ok && (tgt inside {BK_ROW, BK_RD, BK_WR})
                     && (since_rd >= SAME_L)
                     && (since_wr >= WR2RD_L);
            end
            CMD_WR, CMD_WRA: begin
                ok = bank_ok && (tgt inside {BK_ROW, BK_RD, BK_WR})
                     && (since_rd >= RD2WR_L)
                     && (since_wr >= SAME_L);
            end
            CMD_PRE:  ok = bank_ok && pre_ok[c.bank];
            CMD_PREA: ok = &pre_ok;
            CMD_REF, CMD_LM, CMD_SRE: ok = quiet;
            default:  ok = 1'b1;
        endcase
        if (exec && dev_state != DV_RUN) begin
            ok = 1'b0;
        end
        c.take = (chk && exec && ok) || (sre_now && ok);
        bad    = (chk && exec && !ok) || (sre_now && !ok);
    end

    // cycles since the last accepted read and write, saturating
    always_comb begin
        next_since_rd = (&since_rd) ? since_rd : since_rd + 1'b1;
        next_since_wr = (&since_wr) ? since_wr : since_wr + 1'b1;
        if (c.take && c.cmd inside {CMD_RD, CMD_RDA}) begin
            next_since_rd = '0;
        end
        if (c.take && c.cmd inside {CMD_WR, CMD_WRA}) begin
            next_since_wr = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            since_rd <= '1;
            since_wr <= '1;
        end else begin
            since_rd <= next_since_rd;
            since_wr <= next_since_wr;
        end
    end

    // device-wide states: refresh, mode access, precharge all, self refresh
    sdbsc_dev_t       next_dev_state;
    logic [CNT_W-1:0] dcnt, next_dcnt;

    always_comb begin
        next_dev_state = dev_state;
        next_dcnt      = (dcnt != '0) ? dcnt - 1'b1 : dcnt;
        case (dev_state)
            DV_RUN: begin
                if (c.take) begin
                    case (c.cmd)
                        CMD_REF: begin
                            next_dev_state = DV_REF;
                            next_dcnt      = RFC_L;
                        end
                        CMD_LM: begin
                            next_dev_state = DV_MODE;
                            next_dcnt      = MRD_L;
                        end
                        CMD_PREA: begin
                            next_dev_state = DV_PREA;
                            next_dcnt      = RP_L;
                        end
                        CMD_SRE:  next_dev_state = DV_SELF;
                        default:  next_dev_state = DV_RUN;
                    endcase
                end
            end
            DV_REF, DV_MODE, DV_PREA: begin
                if (dcnt == '0) begin
                    next_dev_state = DV_RUN;
                end
            end
            DV_SELF: begin
                if (cke) begin
                    next_dev_state = DV_XIT;
                    next_dcnt      = XSNR_L;
                end
            end
            DV_XIT: begin
                if (dcnt == '0) begin
                    next_dev_state = DV_RUN;
                end
            end
            default: next_dev_state = DV_RUN;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dev_state <= DV_RUN;
            dcnt      <= '0;
        end else begin
            dev_state <= next_dev_state;
            dcnt      <= next_dcnt;
        end
    end

    // violation report: pulse for one cycle, bank and command held until next
    logic             next_viol;
    logic [BA_W-1:0]  next_viol_bank;
    sdbsc_cmd_t       next_viol_cmd;

    always_comb begin
        next_viol      = bad;
        next_viol_bank = bad ? c.bank : viol_bank;
        next_viol_cmd  = bad ? c.cmd : viol_cmd;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            viol      <= 1'b0;
            viol_bank <= '0;
            viol_cmd  <= CMD_DESEL;
        end else begin
            viol      <= next_viol;
            viol_bank <= next_viol_bank;
            viol_cmd  <= next_viol_cmd;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_REF_ENTRY:
    assert property (dev_state == DV_RUN && c.take && c.cmd == CMD_REF |=>
        dev_state == DV_REF && dcnt == RFC_L)
        else $error("refresh did not start the refresh period");
    AST_REF_EXIT:
    assert property (dev_state == DV_REF && dcnt == '0 |=> dev_state == DV_RUN && &bank_idle)
        else $error("refresh period did not end in all idle");
    AST_PREA_EXIT:
    assert property (dev_state == DV_PREA && dcnt == '0 |=> dev_state == DV_RUN && &bank_idle)
        else $error("precharge all did not leave every bank idle");
    AST_BUSY_FLAG:
    assert property (c.live && exec && dev_state inside {DV_REF, DV_MODE, DV_PREA} |=>
        viol && viol_cmd == $past(c.cmd))
        else $error("command during device busy state not flagged");
    AST_NOP_OK:
    assert property (!exec |=> !viol)
        else $error("deselect or nop was flagged");
    AST_NO_CHECK:
    assert property (!c.live && !sre_now |=> !viol ##1 !$past(c.take, 2))
        else $error("command checked without clock enable held");
    AST_WTR_GAP:
    assert property (chk && c.cmd inside {CMD_RD, CMD_RDA} && since_wr < WR2RD_L |=>
        viol && viol_bank == $past(c.bank))
        else $error("read too soon after write not flagged");
    AST_RD_WR:
    assert property (chk && c.cmd inside {CMD_WR, CMD_WRA} && since_rd < RD2WR_L |=> viol)
        else $error("write during read burst not flagged");
endmodule

// [sdbsc_ctl_model.sv]
// sdbsc_ctl_model.sv: behavioural memory controller driving the command pins
// assumes one call per clock; pins change only at falling edges
`timescale 1ns/10ps
module sdbsc_ctl_model
    import sdbsc_pkg::*;
(
    // clock
    input  wire logic       ref_clk,
    // command pins
    output logic            cke,
    output logic            cs_n,
    output logic            ras_n,
    output logic            cas_n,
    output logic            we_n,
    output logic            a10,
    output logic [BA_W-1:0] ba
);
    initial begin
        cke = 1'h1;
        cs_n = 1'h1;
        {ras_n, cas_n, we_n} = ENC_NOP;
        a10 = 1'h0;
        ba = '0;
    end

    // every call drives one edge, so a command never repeats by accident
    task automatic issue(input sdbsc_cmd_t cmd, input logic [BA_W-1:0] bank, input logic ck);
        @(negedge ref_clk);
        cke <= ck;
        cs_n <= (cmd == CMD_DESEL);
        a10 <= (cmd inside {CMD_RDA, CMD_WRA, CMD_PREA});
        ba <= bank;
        case (cmd)
            CMD_ACT: {ras_n, cas_n, we_n} <= ENC_ACT;
            CMD_RD, CMD_RDA: {ras_n, cas_n, we_n} <= ENC_RD;
            CMD_WR, CMD_WRA: {ras_n, cas_n, we_n} <= ENC_WR;
            CMD_PRE, CMD_PREA: {ras_n, cas_n, we_n} <= ENC_PRE;
            CMD_REF, CMD_SRE: {ras_n, cas_n, we_n} <= ENC_REF;
            CMD_LM: {ras_n, cas_n, we_n} <= ENC_LM;
            default: {ras_n, cas_n, we_n} <= ENC_NOP;
        endcase
    endtask
endmodule

// [sdbsc_checker_tb.sv]
// sdbsc_checker_tb.sv: self-checking bench of the bank state checker
// assumes default counts: rp, rcd 1, rfc, mrd 2, read latency 5, burst 8
`timescale 1ns/10ps
module sdbsc_checker_tb
    import sdbsc_pkg::*;
;
    typedef struct {int due; logic v; sdbsc_cmd_t c; logic [BA_W-1:0] b;} sdbsc_note_t;
    logic            ref_clk = 1'h0;
    logic            rst = 1'h1;
    logic            cke_lvl = 1'h1;
    logic            cke, cs_n, ras_n, cas_n, we_n, a10, viol;
    logic [BA_W-1:0] ba, viol_bank;
    logic [7:0]      bank_idle;
    sdbsc_cmd_t      viol_cmd;
    sdbsc_dev_t      dev_state;
    sdbsc_note_t     notes[$];
    int              num_errors = 0;
    int              checked = 0;
    int              cyc = 0;
    logic [31:0]     rnd = 32'h9;

    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    sdbsc_ctl_model ctl (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .a10(a10), .ba(ba));
    sdbsc_checker dut (.ref_clk(ref_clk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .a10(a10), .ba(ba), .viol(viol), .viol_bank(viol_bank),
        .viol_cmd(viol_cmd), .bank_idle(bank_idle), .dev_state(dev_state));

    task automatic report(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_viol(input sdbsc_note_t n);
        report({8'h0, viol, n.v ? {viol_cmd, viol_bank} : 7'h0}, {8'h0, n.v, n.v ? {n.c, n.b} : 7'h0});
    endtask
    task automatic chk_view(input logic [7:0] idle, input sdbsc_dev_t dv);
        report({bank_idle, 2'h0, dev_state}, {idle, 2'h0, dv});
    endtask
    // the flag answers one edge after the command is taken
    task automatic send(input sdbsc_cmd_t c, input logic [BA_W-1:0] b, input logic v);
        ctl.issue(c, b, cke_lvl);
        notes.push_back('{cyc + 1, v, c, b});
    endtask
    task automatic nop(input int n);
        repeat (n) ctl.issue(CMD_NOP, 3'h0, cke_lvl);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic close_out;
        // a note never reached means an answer was never looked at
        if (notes.size() != 0) num_errors++;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // a flag with no note due is a mismatch as well
    always @(negedge ref_clk) begin
        if (!rst && notes.size() > 0 && notes[0].due == cyc) chk_viol(notes.pop_front());
        else if (!rst && viol !== 1'h0) chk_viol('{cyc, 1'h0, CMD_DESEL, 3'h0});
    end

    initial begin
        #40000;
        num_errors++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'h0;
        chk_view(8'hff, DV_RUN);
        nop(3);
        send(CMD_ACT, 3'h0, 1'h0);
        send(CMD_RD, 3'h0, 1'h1);
        send(CMD_RD, 3'h0, 1'h0);
        send(CMD_WR, 3'h0, 1'h1);
        nop(6);
        send(CMD_WR, 3'h1, 1'h1);
        send(CMD_ACT, 3'h1, 1'h0);
        send(CMD_REF, 3'h0, 1'h1);
        nop(1);
        send(CMD_PREA, 3'h0, 1'h0);
        send(CMD_ACT, 3'h2, 1'h1);
        nop(2);
        chk_view(8'hff, DV_RUN);
        $display("test bank states done");
        send(CMD_REF, 3'h0, 1'h0);
        send(CMD_ACT, 3'h3, 1'h1);
        chk_view(8'hff, DV_REF);
        nop(2);
        send(CMD_LM, 3'h0, 1'h0);
        send(CMD_ACT, 3'h3, 1'h1);
        nop(2);
        $display("test device states done");
        send(CMD_ACT, 3'h0, 1'h0);
        send(CMD_ACT, 3'h1, 1'h0);
        nop(1);
        send(CMD_RDA, 3'h0, 1'h0);
        send(CMD_RD, 3'h1, 1'h1);
        nop(2);
        send(CMD_RD, 3'h1, 1'h0);
        nop(4);
        chk_view(8'hfd, DV_RUN);
        $display("test auto precharge done");
        cke_lvl = 1'h0;
        nop(1);
        send(CMD_WR, 3'h2, 1'h0);
        cke_lvl = 1'h1;
        nop(2);
        $display("test clock enable done");
        send(CMD_ACT, 3'h0, 1'h0);
        send(CMD_WR, 3'h1, 1'h0);
        send(CMD_PRE, 3'h1, 1'h1);
        send(CMD_RD, 3'h0, 1'h1);
        send(CMD_WRA, 3'h0, 1'h1);
        send(CMD_WRA, 3'h0, 1'h0);
        nop(8);
        send(CMD_RD, 3'h1, 1'h1);
        send(CMD_RD, 3'h1, 1'h0);
        nop(1);
        chk_view(8'hfd, DV_RUN);
        send(CMD_PREA, 3'h0, 1'h0);
        nop(7);
        $display("test write auto precharge done");
        cke_lvl = 1'h0;
        send(CMD_SRE, 3'h0, 1'h0);
        nop(2);
        chk_view(8'hff, DV_SELF);
        cke_lvl = 1'h1;
        send(CMD_ACT, 3'h2, 1'h0);
        send(CMD_ACT, 3'h2, 1'h0);
        chk_view(8'hff, DV_XIT);
        nop(1);
        send(CMD_RD, 3'h2, 1'h1);
        $display("test self refresh done");
        repeat (30) begin
            rnd = xs(rnd);
            send(rnd[0] ? CMD_DESEL : CMD_NOP, rnd[3:1], 1'h0);
        end
        nop(3);
        $display("test idle traffic done");
        close_out();
    end
endmodule
